// file: design/vfd_top.sv
// Frame DMA pointers, event status with masks, and monitor border timing
`timescale 1ns/1ps
// Function
// (R1) Four 8-bit border count fields
// (R2) Horizontal border begins field+1 pixels after back porch
// (R3) Trailing horizontal border lasts field+1 pixels
// (R4) Vertical border begins field+1 lines after back porch
// (R5) Trailing vertical border lasts field lines exactly
// (R6) Border shows 24-bit RGB colour
// (R7) Software writes base aligned, low six zero
// (R8) Base pointer keeps only bits 25-6
// (R9) Frame start copies base, sets next flag
// (R10) Base write clears next flag
// (R11) Software sets base before enable, after next
// (R12) Current pointer read-only, tracks fetch
// (R13) Interrupt is OR of status AND mask
// (R14) Disable finishes frame, then sets done
// (R15) Done cleared by base, enable, or W1C
// (R16) Underflow sticky until written one
// (R17) Vertical compare sticky until written one
// (R18) Monitor status same, no done bit
// (R19) Monitor has own base and current pointers
// (R20) Status zero and interrupt low after reset
module vfd_top
    import vfd_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Panel timing and fetch events, one-cycle pulses
    input wire logic panel_frame_start,
    input wire logic panel_frame_end,
    input wire logic panel_fetch_step,
    input wire logic panel_fifo_underrun,
    input wire logic panel_vert_region,
    // Monitor timing and fetch events, one-cycle pulses
    input wire logic mon_frame_start,
    input wire logic mon_fetch_step,
    input wire logic mon_fifo_underrun,
    input wire logic mon_vert_region,
    input wire logic mon_pixel_tick,
    input wire logic mon_line_tick,
    input wire logic mon_hbp_start,
    input wire logic mon_hactive_start,
    input wire logic mon_hactive_end,
    input wire logic mon_vbp_start,
    input wire logic mon_vactive_start,
    input wire logic mon_vfp_start,
    // Block outputs
    output logic panel_active,
    output logic mon_active,
    output logic [25:0] panel_fetch_addr,
    output logic [25:0] mon_fetch_addr,
    output logic mon_border_on,
    output logic [23:0] border_rgb,
    output logic panel_irq,
    output logic mon_irq
);
    // ==========================================================
    // Register state
    logic [1:0] ctl_q; // Enable bits as written
    logic panel_active_q; // Panel runs until its frame ends
    logic [3:0] pstat_q; // Panel sticky events
    logic [3:0] pmask_q; // Panel mask
    logic [2:0] mstat_q; // Monitor sticky events, no done
    logic [2:0] mmask_q; // Monitor mask
    logic [19:0] pbase_q; // Panel base pointer
    logic [19:0] pcur_q; // Panel current pointer
    logic [19:0] mbase_q; // Monitor base pointer
    logic [19:0] mcur_q; // Monitor current pointer
    logic [31:0] btim_q; // Border count fields
    logic [23:0] border_rgb_q; // Border colour
    logic panel_irq_q;
    logic mon_irq_q;

    // ==========================================================
    // AXI4-Lite handshake
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic wr_en; // Both halves of a write are in hand
    logic [31:0] wmask; // Byte lanes widened to bits
    logic [31:0] wset; // Written ones within enabled lanes
    logic [5:0] widx;
    logic wr_ctrl, wr_pstat, wr_pmask, wr_pbase;
    logic wr_mstat, wr_mmask, wr_mbase, wr_btim, wr_border_rgb;
    logic wr_known;

    assign wr_en = !awready_q && !wready_q && !bvalid_q;
    assign widx = awaddr_q[7:2];

    // Byte enables to a bit mask, one lane per pass
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_lane
            assign wmask[gi*8 +: 8] = {8{wstrb_q[gi]}};
        end
    endgenerate
    assign wset = wdata_q & wmask;

    // Write decode on the word index
    assign wr_ctrl = wr_en && (widx == VFD_OFF_CONTROL[7:2]);
    assign wr_pstat = wr_en && (widx == VFD_OFF_PSTATUS[7:2]);
    assign wr_pmask = wr_en && (widx == VFD_OFF_PMASK[7:2]);
    assign wr_pbase = wr_en && (widx == VFD_OFF_PBASE[7:2]);
    assign wr_mstat = wr_en && (widx == VFD_OFF_MSTATUS[7:2]);
    assign wr_mmask = wr_en && (widx == VFD_OFF_MMASK[7:2]);
    assign wr_mbase = wr_en && (widx == VFD_OFF_MBASE[7:2]);
    assign wr_btim = wr_en && (widx == VFD_OFF_BTIMING[7:2]);
    assign wr_border_rgb = wr_en && (widx == VFD_OFF_BCOLOUR[7:2]);
    // Read-only words accept a write silently
    assign wr_known = wr_ctrl || wr_pstat || wr_pmask || wr_pbase || wr_mstat
        || wr_mmask || wr_mbase || wr_btim || wr_border_rgb
        || (widx == VFD_OFF_PINT[7:2]) || (widx == VFD_OFF_PCUR[7:2])
        || (widx == VFD_OFF_MINT[7:2]) || (widx == VFD_OFF_MCUR[7:2]);

    // Address and data in either order, then answer
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= VFD_RESP_OKAY;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && awready_q)
            begin
                awaddr_q <= s_axi_awaddr;
                awready_q <= 1'b0;
            end
            if (s_axi_wvalid && wready_q)
            begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                wready_q <= 1'b0;
            end
            if (wr_en)
            begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_known ? VFD_RESP_OKAY : VFD_RESP_SLVERR;
            end
            else if (bvalid_q && s_axi_bready)
            begin
                // Reopen channels once the answer is taken
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    // Read mux; undefined pointer bits read as zero
    function automatic logic [32:0] read_word(input logic [5:0] idx);
        logic [32:0] r;
        r = {1'b1, 32'h00000000};
        unique case (idx)
            VFD_OFF_CONTROL[7:2]: r[31:0] = {30'h0, ctl_q};
            VFD_OFF_PSTATUS[7:2]: r[31:0] = {28'h0, pstat_q};
            VFD_OFF_PMASK[7:2]: r[31:0] = {28'h0, pmask_q};
            VFD_OFF_PINT[7:2]: r[31:0] = {28'h0, pstat_q & pmask_q};
            VFD_OFF_PBASE[7:2]: r[31:0] = {6'h0, pbase_q, 6'h0};
            VFD_OFF_PCUR[7:2]: r[31:0] = {6'h0, pcur_q, 6'h0};
            VFD_OFF_MSTATUS[7:2]: r[31:0] = {29'h0, mstat_q};
            VFD_OFF_MMASK[7:2]: r[31:0] = {29'h0, mmask_q};
            VFD_OFF_MINT[7:2]: r[31:0] = {29'h0, mstat_q & mmask_q};
            VFD_OFF_MBASE[7:2]: r[31:0] = {6'h0, mbase_q, 6'h0};
            VFD_OFF_MCUR[7:2]: r[31:0] = {6'h0, mcur_q, 6'h0};
            VFD_OFF_BTIMING[7:2]: r[31:0] = btim_q;
            VFD_OFF_BCOLOUR[7:2]: r[31:0] = {8'h0, border_rgb_q};
            default: r[32] = 1'b0; // Unmapped word
        endcase
        return r;
    endfunction

    // One read at a time, answered next cycle
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= VFD_RESP_OKAY;
        end
        else if (s_axi_arvalid && arready_q)
        begin
            logic [32:0] rw;
            rw = read_word(s_axi_araddr[7:2]);
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rw[31:0];
            rresp_q <= rw[32] ? VFD_RESP_OKAY : VFD_RESP_SLVERR;
        end
        else if (rvalid_q && s_axi_rready)
        begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // ==========================================================
    // Control, masks and border configuration
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctl_q <= VFD_CTL_RESET;
            pmask_q <= VFD_MASK_RESET;
            mmask_q <= VFD_MASK_RESET[2:0];
            btim_q <= VFD_BTIMING_RESET;
            border_rgb_q <= VFD_BCOLOUR_RESET;
        end
        else
        begin
            if (wr_ctrl && wstrb_q[0])
                ctl_q <= wdata_q[1:0];
            if (wr_pmask && wstrb_q[0])
                pmask_q <= wdata_q[3:0];
            if (wr_mmask && wstrb_q[0])
                mmask_q <= wdata_q[2:0];
            if (wr_btim)
                btim_q <= (btim_q & ~wmask) | wset; // R1
            if (wr_border_rgb)
                border_rgb_q <= (border_rgb_q & ~wmask[23:0]) | wset[23:0]; // R6
        end
    end

    // ==========================================================
    // Enables: panel drains its frame, monitor stops at once
    logic panel_en_rise;
    assign panel_en_rise = wr_ctrl && wstrb_q[0] && wdata_q[VFD_CTL_PANEL_EN];
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            panel_active_q <= 1'b0;
        else if (panel_en_rise)
            panel_active_q <= 1'b1;
        else if (panel_frame_end && !ctl_q[VFD_CTL_PANEL_EN])
            panel_active_q <= 1'b0; // R14
    end

    // ==========================================================
    // Pointers; base keeps only address bits 25-6
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pbase_q <= VFD_PTR_RESET;
            mbase_q <= VFD_PTR_RESET;
            pcur_q <= VFD_PTR_RESET;
            mcur_q <= VFD_PTR_RESET;
        end
        else
        begin
            if (wr_pbase)
                pbase_q <= (pbase_q & ~wmask[VFD_PTR_MSB:VFD_PTR_LSB])
                    | wset[VFD_PTR_MSB:VFD_PTR_LSB]; // R8
            if (wr_mbase)
                mbase_q <= (mbase_q & ~wmask[VFD_PTR_MSB:VFD_PTR_LSB])
                    | wset[VFD_PTR_MSB:VFD_PTR_LSB]; // R19
            // Frame start reloads, fetch steps one 16-word burst
            if (panel_frame_start && panel_active_q)
                pcur_q <= pbase_q; // R9
            else if (panel_fetch_step && panel_active_q)
                pcur_q <= pcur_q + 20'h00001; // R12
            if (mon_frame_start && ctl_q[VFD_CTL_MON_EN])
                mcur_q <= mbase_q; // R19
            else if (mon_fetch_step && ctl_q[VFD_CTL_MON_EN])
                mcur_q <= mcur_q + 20'h00001; // R19
        end
    end

    // ==========================================================
    // Panel status: a set in the same cycle beats any clear
    logic [3:0] pset;
    logic [3:0] pclr;
    assign pset[VFD_ST_UNDERFLOW] = panel_fifo_underrun; // R16
    assign pset[VFD_ST_NEXT] = panel_frame_start && panel_active_q; // R9
    assign pset[VFD_ST_VERTICAL_COMPARE_FLAG] = panel_vert_region; // R17
    assign pset[VFD_ST_DONE] = panel_frame_end && panel_active_q
        && !ctl_q[VFD_CTL_PANEL_EN]; // R14
    assign pclr[VFD_ST_UNDERFLOW] = wr_pstat && wset[VFD_ST_UNDERFLOW]; // R16
    assign pclr[VFD_ST_NEXT] = wr_pbase; // R10
    assign pclr[VFD_ST_VERTICAL_COMPARE_FLAG] = wr_pstat && wset[VFD_ST_VERTICAL_COMPARE_FLAG]; // R17
    assign pclr[VFD_ST_DONE] = wr_pbase || panel_en_rise
        || (wr_pstat && wset[VFD_ST_DONE]); // R15
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            pstat_q <= VFD_STATUS_RESET; // R20
        else
            pstat_q <= pset | (pstat_q & ~pclr);
    end

    // Monitor status, no done bit
    logic [2:0] mset;
    logic [2:0] mclr;
    assign mset = {mon_vert_region, mon_frame_start && ctl_q[VFD_CTL_MON_EN],
        mon_fifo_underrun}; // R18
    assign mclr = {wr_mstat && wset[VFD_ST_VERTICAL_COMPARE_FLAG], wr_mbase,
        wr_mstat && wset[VFD_ST_UNDERFLOW]}; // R18
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            mstat_q <= VFD_STATUS_RESET[2:0]; // R20
        else
            mstat_q <= mset | (mstat_q & ~mclr);
    end

    // Registered interrupt outputs
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            panel_irq_q <= 1'b0;
            mon_irq_q <= 1'b0;
        end
        else
        begin
            panel_irq_q <= |(pstat_q & pmask_q); // R13
            mon_irq_q <= |(mstat_q & mmask_q); // R13
        end
    end

    // ==========================================================
    // Border counters; 9 bits so field+1 cannot wrap
    logic [8:0] hl_cnt_q, ht_cnt_q, vl_cnt_q, vt_cnt_q;
    logic hl_wait_q, hl_on_q, ht_on_q, vl_wait_q, vl_on_q, vt_on_q;
    logic border_q;
    logic [23:0] rgb_q;

    // Leading horizontal border
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hl_cnt_q <= VFD_CNT_RESET;
            hl_wait_q <= 1'b0;
            hl_on_q <= 1'b0;
        end
        else if (mon_hbp_start)
        begin
            hl_cnt_q <= {1'b0, btim_q[VFD_HB_BEGIN_LSB +: 8]} + 9'h001; // R2
            hl_wait_q <= 1'b1;
            hl_on_q <= 1'b0;
        end
        else if (mon_hactive_start)
        begin
            hl_wait_q <= 1'b0;
            hl_on_q <= 1'b0;
        end
        else if (hl_wait_q && mon_pixel_tick)
        begin
            if (hl_cnt_q == 9'h001)
            begin
                hl_wait_q <= 1'b0;
                hl_on_q <= 1'b1; // R2
            end
            else
                hl_cnt_q <= hl_cnt_q - 9'h001;
        end
    end

    // Trailing horizontal border after active data
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ht_cnt_q <= VFD_CNT_RESET;
            ht_on_q <= 1'b0;
        end
        else if (mon_hactive_end)
        begin
            ht_cnt_q <= {1'b0, btim_q[VFD_HB_LEN_LSB +: 8]} + 9'h001; // R3
            ht_on_q <= 1'b1;
        end
        else if (ht_on_q && mon_pixel_tick)
        begin
            if (ht_cnt_q == 9'h001)
                ht_on_q <= 1'b0; // R3
            else
                ht_cnt_q <= ht_cnt_q - 9'h001;
        end
    end

    // Leading vertical border
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            vl_cnt_q <= VFD_CNT_RESET;
            vl_wait_q <= 1'b0;
            vl_on_q <= 1'b0;
        end
        else if (mon_vbp_start)
        begin
            vl_cnt_q <= {1'b0, btim_q[VFD_VB_BEGIN_LSB +: 8]} + 9'h001; // R4
            vl_wait_q <= 1'b1;
            vl_on_q <= 1'b0;
        end
        else if (mon_vactive_start)
        begin
            vl_wait_q <= 1'b0;
            vl_on_q <= 1'b0;
        end
        else if (vl_wait_q && mon_line_tick)
        begin
            if (vl_cnt_q == 9'h001)
            begin
                vl_wait_q <= 1'b0;
                vl_on_q <= 1'b1; // R4
            end
            else
                vl_cnt_q <= vl_cnt_q - 9'h001;
        end
    end

    // Trailing vertical border; a zero field gives none
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            vt_cnt_q <= VFD_CNT_RESET;
            vt_on_q <= 1'b0;
        end
        else if (mon_vfp_start)
        begin
            vt_cnt_q <= {1'b0, btim_q[VFD_VB_LEN_LSB +: 8]}; // R5
            vt_on_q <= (btim_q[VFD_VB_LEN_LSB +: 8] != 8'h00);
        end
        else if (vt_on_q && mon_line_tick)
        begin
            if (vt_cnt_q == 9'h001)
                vt_on_q <= 1'b0; // R5
            else
                vt_cnt_q <= vt_cnt_q - 9'h001;
        end
    end

    // Border output, gated by monitor enable
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            border_q <= 1'b0;
            rgb_q <= VFD_BCOLOUR_RESET;
        end
        else
        begin
            border_q <= ctl_q[VFD_CTL_MON_EN]
                && (hl_on_q || ht_on_q || vl_on_q || vt_on_q);
            rgb_q <= border_rgb_q; // R6
        end
    end

    // ==========================================================
    // Output wiring, all from flip-flops
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign panel_active = panel_active_q;
    assign mon_active = ctl_q[VFD_CTL_MON_EN];
    assign panel_fetch_addr = {pcur_q, 6'h00};
    assign mon_fetch_addr = {mcur_q, 6'h00};
    assign mon_border_on = border_q;
    assign border_rgb = rgb_q;
    assign panel_irq = panel_irq_q;
    assign mon_irq = mon_irq_q;

    // ==========================================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    next_frame_set_a: assert property (panel_frame_start && panel_active_q // R9
        |=> pstat_q[VFD_ST_NEXT] && pcur_q == $past(pbase_q))
        else $error("next frame missed");
    base_clears_next_a: assert property (wr_pbase && !pset[VFD_ST_NEXT] // R10
        |=> !pstat_q[VFD_ST_NEXT])
        else $error("next not cleared");
    irq_from_mask_a: assert property (##1 panel_irq_q // R13
        == $past(|(pstat_q & pmask_q)))
        else $error("irq mismatch");
    done_after_frame_a: assert property (pset[VFD_ST_DONE] // R14
        |=> pstat_q[VFD_ST_DONE] && !panel_active_q)
        else $error("done not set");
    done_clear_a: assert property (pclr[VFD_ST_DONE] && !pset[VFD_ST_DONE] // R15
        |=> !pstat_q[VFD_ST_DONE])
        else $error("frame done not cleared");
    underflow_sticky_a: assert property (pstat_q[VFD_ST_UNDERFLOW] // R16
        && !pclr[VFD_ST_UNDERFLOW] |=> pstat_q[VFD_ST_UNDERFLOW])
        else $error("underflow lost");
    vertical_compare_flag_set_a: assert property (panel_vert_region // R17
        |=> pstat_q[VFD_ST_VERTICAL_COMPARE_FLAG])
        else $error("vertical_compare_flag not set");
    mon_stop_now_a: assert property (wr_ctrl && wstrb_q[0] // Monitor stops at once
        && !wdata_q[VFD_CTL_MON_EN] |=> !mon_active ##1 !border_q)
        else $error("monitor not stopped");
    htrail_len_a: assert property (mon_hactive_end // R3
        && btim_q[VFD_HB_LEN_LSB +: 8] == 8'h00 ##1 (mon_pixel_tick
        && !mon_hactive_end) |=> !ht_on_q)
        else $error("trail too long");
    irq_quiet_a: assert property (pstat_q == 4'h0 ##1 pstat_q == 4'h0 // R20
        |-> !panel_irq_q)
        else $error("stray irq");
endmodule

// file: inc/vfd_pkg.sv
// Constants shared by the video frame DMA, status and border block
package vfd_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] VFD_OFF_CONTROL = 8'h00;
    localparam logic [7:0] VFD_OFF_PSTATUS = 8'h04;
    localparam logic [7:0] VFD_OFF_PMASK = 8'h08;
    localparam logic [7:0] VFD_OFF_PINT = 8'h0c;
    localparam logic [7:0] VFD_OFF_PBASE = 8'h10;
    localparam logic [7:0] VFD_OFF_PCUR = 8'h14;
    localparam logic [7:0] VFD_OFF_MSTATUS = 8'h44;
    localparam logic [7:0] VFD_OFF_MMASK = 8'h48;
    localparam logic [7:0] VFD_OFF_MINT = 8'h4c;
    localparam logic [7:0] VFD_OFF_MBASE = 8'h50;
    localparam logic [7:0] VFD_OFF_MCUR = 8'h54;
    localparam logic [7:0] VFD_OFF_BTIMING = 8'h6c;
    localparam logic [7:0] VFD_OFF_BCOLOUR = 8'h70;
    // ==========================================================
    // Field positions
    localparam int VFD_CTL_PANEL_EN = 0;
    localparam int VFD_CTL_MON_EN = 1;
    localparam int VFD_ST_UNDERFLOW = 0;
    localparam int VFD_ST_NEXT = 1;
    localparam int VFD_ST_VERTICAL_COMPARE_FLAG = 2;
    localparam int VFD_ST_DONE = 3;
    localparam int VFD_PTR_LSB = 6;
    localparam int VFD_PTR_MSB = 25;
    localparam int VFD_HB_BEGIN_LSB = 0;
    localparam int VFD_HB_LEN_LSB = 8;
    localparam int VFD_VB_BEGIN_LSB = 16;
    localparam int VFD_VB_LEN_LSB = 24;
    // ==========================================================
    // Reset values
    localparam logic [1:0] VFD_CTL_RESET = 2'h0;
    localparam logic [3:0] VFD_STATUS_RESET = 4'h0;
    localparam logic [3:0] VFD_MASK_RESET = 4'h0;
    localparam logic [19:0] VFD_PTR_RESET = 20'h00000;
    localparam logic [31:0] VFD_BTIMING_RESET = 32'h00000000;
    localparam logic [23:0] VFD_BCOLOUR_RESET = 24'h000000;
    localparam logic [8:0] VFD_CNT_RESET = 9'h000;
    // ==========================================================
    // Bus answers
    localparam logic [1:0] VFD_RESP_OKAY = 2'h0;
    localparam logic [1:0] VFD_RESP_SLVERR = 2'h2;
endpackage

// file: verification/vfd_line_model.sv
// Monitor line timing model driving the horizontal border inputs
`timescale 1ns/1ps
module vfd_line_model
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic run,
    output logic pixel_tick,
    output logic hbp_start,
    output logic hactive_start,
    output logic hactive_end
);
    // ==========================================
    // Line position, 32 pixels, one per clock
    logic [4:0] pos_q;
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            pos_q <= 5'h00;
        else if (run)
            pos_q <= pos_q + 5'h01;
    end
    // Porch marks; lead and trail never overlap
    assign pixel_tick = run;
    assign hbp_start = run && pos_q == 5'h00;
    assign hactive_start = run && pos_q == 5'h08;
    assign hactive_end = run && pos_q == 5'h14;
endmodule

// file: verification/tb_vfd_top.sv
// Bench for the frame DMA, status and border block
`timescale 1ns/1ps
module tb_vfd_top import vfd_pkg::*;;
    // ==========================================
    // Stimulus and observed signals
    logic mclk = 1'b0, rst_n = 1'b0, av = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic run = 1'b0;
    logic [7:0] aa = 8'h00, ra = 8'h00;
    logic [31:0] wd = 32'h0, rdv, rd;
    logic [12:0] ev = 13'h0;
    logic awr, wrdy, bv, arr, rv, pa, ma, bon, pirq, mirq, pix, hbp, has, hae;
    logic [25:0] pfa;
    logic [1:0] rsp, rresp;
    logic [23:0] rgb;
    int n_mismatch = 0, check_count = 0, n0, n1;
    vfd_top vfd_top_inst (.mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(aa), .s_axi_awvalid(av),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wrdy), .s_axi_bresp(), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ra), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .panel_frame_start(ev[0]), .panel_frame_end(ev[1]), .panel_fetch_step(ev[2]),
        .panel_fifo_underrun(ev[3]), .panel_vert_region(ev[4]), .mon_frame_start(ev[5]),
        .mon_fetch_step(ev[6]), .mon_fifo_underrun(ev[7]), .mon_vert_region(ev[8]),
        .mon_pixel_tick(pix), .mon_line_tick(ev[9]), .mon_hbp_start(hbp),
        .mon_hactive_start(has), .mon_hactive_end(hae), .mon_vbp_start(ev[10]),
        .mon_vactive_start(ev[11]), .mon_vfp_start(ev[12]), .panel_active(pa),
        .mon_active(ma), .panel_fetch_addr(pfa), .mon_fetch_addr(), .mon_border_on(bon),
        .border_rgb(rgb), .panel_irq(pirq), .mon_irq(mirq));
    vfd_line_model vfd_line_model_inst (.mclk(mclk), .rst_n(rst_n), .run(run),
        .pixel_tick(pix), .hbp_start(hbp), .hactive_start(has), .hactive_end(hae));
    // ==========================================
    // Verdict, compare and bus tasks
    task automatic tally_and_finish;
        if (n_mismatch == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Timeout counts as a mismatch
    task automatic to(input bit ok);
        if (!ok)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask
    // Write: both channels, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit ha, hw, hb = 0;
        @(posedge mclk);
        {aa, wd, av, wv, br} <= {a, d, 3'b111};
        for (int i = 0; i < 20 && !hb; i++)
        begin
            @(negedge mclk);
            {ha, hw, hb} = {av && awr, wv && wrdy, bv};
            @(posedge mclk);
            av <= av && !ha;
            wv <= wv && !hw;
            br <= !hb;
        end
        to(hb);
    endtask
    // Read one word, compare, keep response in rsp
    task automatic chk(input logic [7:0] a, input logic [31:0] e);
        bit ha, hr = 0;
        @(posedge mclk);
        {ra, arv, rr} <= {a, 2'b11};
        for (int i = 0; i < 20 && !hr; i++)
        begin
            @(negedge mclk);
            {ha, hr, rdv, rsp} = {arv && arr, rv, rd, rresp};
            @(posedge mclk);
            arv <= arv && !ha;
            rr <= !hr;
        end
        to(hr);
        cmp(rdv, e);
    endtask
    task automatic pulse(input int b);
        @(posedge mclk);
        ev[b] <= 1'b1;
        @(posedge mclk);
        ev[b] <= 1'b0;
    endtask
    // Border cycles in one settled line
    task automatic meas(output int n);
        n = 0;
        repeat (32) @(negedge mclk);
        repeat (32) @(negedge mclk) if (bon === 1'b1) n++;
    endtask
    // ==========================================
    // Scenarios
    task automatic t_panel;
        chk(VFD_OFF_PSTATUS, 32'h0);
        cmp(pirq, 1'b0);
        wr(VFD_OFF_PBASE, 32'h03ffffc0);
        chk(VFD_OFF_PBASE, 32'h03ffffc0);
        wr(VFD_OFF_PBASE, 32'h00001040);
        wr(VFD_OFF_CONTROL, 32'h1);
        pulse(0);
        chk(VFD_OFF_PCUR, 32'h00001040);
        chk(VFD_OFF_PSTATUS, 32'h2);
        wr(VFD_OFF_PCUR, 32'h0);
        pulse(2);
        chk(VFD_OFF_PCUR, 32'h00001080);
        cmp(pfa, 32'h1080);
        wr(VFD_OFF_PMASK, 32'h2);
        chk(VFD_OFF_PINT, 32'h2);
        cmp(pirq, 1'b1);
        wr(VFD_OFF_PBASE, 32'h00002000);
        chk(VFD_OFF_PSTATUS, 32'h0);
        cmp(pirq, 1'b0);
    endtask
    task automatic t_events;
        wr(VFD_OFF_PMASK, 32'h5);
        pulse(3);
        pulse(4);
        chk(VFD_OFF_PSTATUS, 32'h5);
        wr(VFD_OFF_PSTATUS, 32'h1);
        chk(VFD_OFF_PSTATUS, 32'h4);
        cmp(pirq, 1'b1);
        wr(VFD_OFF_PSTATUS, 32'h4);
        chk(VFD_OFF_PSTATUS, 32'h0);
        wr(VFD_OFF_CONTROL, 32'h0);
        @(negedge mclk);
        cmp(pa, 1'b1);
        pulse(1);
        chk(VFD_OFF_PSTATUS, 32'h8);
        cmp(pa, 1'b0);
        wr(VFD_OFF_CONTROL, 32'h3);
        chk(VFD_OFF_PSTATUS, 32'h0);
        wr(VFD_OFF_CONTROL, 32'h2);
        pulse(1);
        wr(VFD_OFF_PSTATUS, 32'h8);
        chk(VFD_OFF_PSTATUS, 32'h0);
        wr(VFD_OFF_CONTROL, 32'h3);
    endtask
    task automatic t_monitor;
        wr(VFD_OFF_MBASE, 32'h00003040);
        pulse(5);
        pulse(7);
        chk(VFD_OFF_MCUR, 32'h00003040);
        chk(VFD_OFF_MSTATUS, 32'h3);
        wr(VFD_OFF_MMASK, 32'h1);
        chk(VFD_OFF_MINT, 32'h1);
        cmp(mirq, 1'b1);
        cmp(ma, 1'b1);
        chk(8'h3c, 32'h0);
        cmp(rsp, VFD_RESP_SLVERR);
    endtask
    task automatic t_border;
        wr(VFD_OFF_BCOLOUR, 32'h00a5c3e7);
        run <= 1'b1;
        wr(VFD_OFF_BTIMING, 32'h0);
        cmp(rgb, 24'ha5c3e7);
        meas(n0);
        wr(VFD_OFF_BTIMING, 32'h4);
        meas(n1);
        cmp(n0 - n1, 32'h4);
        wr(VFD_OFF_BTIMING, 32'h400);
        meas(n1);
        cmp(n1 - n0, 32'h4);
        chk(VFD_OFF_BTIMING, 32'h400);
    endtask
    // ==========================================
    // Clock, reset and main sequence
    initial
    begin
        forever #50 mclk = ~mclk;
    end
    initial
    begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        t_panel();
        t_events();
        t_monitor();
        t_border();
        tally_and_finish();
    end
endmodule
